/* rtl/smram_pkg.sv */
package smram_pkg;

  // configuration space offsets (byte offsets on the config port)
  localparam logic [7:0] SMM_RAM_CONTROL_OFS = 8'h72;
  localparam logic [7:0] EXT_STATUS_OFS      = 8'h71;

  // smm_ram_control field positions, plus the error bit of the extended status register
  localparam int OPEN_POS   = 6;
  localparam int CLOSED_POS = 5;
  localparam int LOCKED_POS = 4;
  localparam int GLOBAL_POS = 3;
  localparam int ERROR_POS  = 6;

  // smm_ram_control reset and hardwired base segment
  localparam logic [7:0] SMM_RAM_CONTROL_RST = 8'h02;
  localparam logic [2:0] COMPAT_BASE_SEGMENT = 3'b010;

  // address windows
  localparam logic [31:0] A_SEG_BASE = 32'h000A_0000;
  localparam logic [31:0] A_SEG_LAST = 32'h000B_FFFF;
  localparam logic [31:0] HIGH_BASE  = 32'h100A_0000;
  localparam logic [31:0] HIGH_LAST  = 32'h100F_FFFF;

  // top segment sizes for encodings 00, 01, 10, 11
  localparam logic [31:0] TOP_SIZE_0 = 32'h0002_0000;
  localparam logic [31:0] TOP_SIZE_1 = 32'h0004_0000;
  localparam logic [31:0] TOP_SIZE_2 = 32'h0008_0000;
  localparam logic [31:0] TOP_SIZE_3 = 32'h0010_0000;

  // which window an access falls into
  typedef enum logic [1:0] {
    REGION_NONE,
    REGION_A,
    REGION_HIGH,
    REGION_TOP
  } region_type;

endpackage

/* rtl/smram_region_match.sv */
`timescale 1ns/1ps
// classifies a host address into the three management windows
module smram_region_match
  import smram_pkg::*;
(
  input  wire logic [31:0] addr,      // host address
  input  wire logic [1:0]  top_size,  // top segment size encoding
  input  wire logic [31:0] tom_addr,  // top of memory, one past last byte
  output region_type       region     // window hit
);

  // size of the top segment for a given encoding
  function automatic logic [31:0] top_bytes(input logic [1:0] enc);
    case (enc)
      2'b00:   top_bytes = TOP_SIZE_0;
      2'b01:   top_bytes = TOP_SIZE_1;
      2'b10:   top_bytes = TOP_SIZE_2;
      default: top_bytes = TOP_SIZE_3;
    endcase
  endfunction

  logic [31:0] top_base;

  // top segment ends at top of memory
  assign top_base = tom_addr - top_bytes(top_size); // R17

  // a fixed segment is never relocated, only matched in place
  always_comb begin
    if (addr >= A_SEG_BASE && addr <= A_SEG_LAST) begin // R8 R9
      region = REGION_A;
    end else if (addr >= HIGH_BASE && addr <= HIGH_LAST) begin // R15
      region = REGION_HIGH;
    end else if (addr >= top_base && addr < tom_addr) begin // R17
      region = REGION_TOP;
    end else begin
      region = REGION_NONE;
    end
  end

endmodule

/* rtl/smram_access_decoder.sv */
`timescale 1ns/1ps
// What this block does
// [R1] open, close, lock act only with global enable
// [R2] software clears open before setting lock
// [R3] open and unlocked maps space without management mode
// [R4] software never sets open and closed together
// [R5] closed blocks data, code fetches still reach DRAM
// [R6] lock forces open low; both then read-only
// [R7] global enable exposes A segment in management mode
// [R8] base segment hardwired 010, A0000 to BFFFF
// [R9] no relocation: same DRAM address or PCI
// [R10] PCI initiators never reach management DRAM
// [R11] open, no extended enables: A to DRAM
// [R12] top enable only: A and top to DRAM
// [R13] high enable only: high region to DRAM
// [R14] both enables: high and top to DRAM
// [R15] high region spans 100A0000 to 100FFFFF
// [R16] outside access flags error; write one clears
// [R17] top size 00..11 gives 128K..1M below top
// [R18] global enable low sends everything to PCI
// [R19] no management mode, not open: all PCI
// [R20] reset clears enable, open, closed, locked bits
module smram_access_decoder
  import smram_pkg::*;
(
  input  wire logic        sys_clk,             // host clock
  input  wire logic        rst,                 // power-on reset, active high
  input  wire logic        cfg_wr,              // config write strobe
  input  wire logic        cfg_rd,              // config read strobe
  input  wire logic [7:0]  cfg_addr,            // config byte offset
  input  wire logic [7:0]  cfg_wdata,           // config write data
  output logic      [7:0]  cfg_rdata,           // config read data
  input  wire logic        addr_strobe_n,       // host cycle start, active low
  input  wire logic [31:0] host_addr,           // host address
  input  wire logic        code_fetch,          // cycle is a code fetch
  input  wire logic        pci_initiator,       // cycle comes from a PCI master
  input  wire logic        mgmt_mode_active_n,  // management mode, active low
  input  wire logic        high_region_enable,  // extended high region on
  input  wire logic        top_segment_enable,  // top segment on
  input  wire logic [1:0]  top_segment_size,    // top segment size encoding
  input  wire logic [31:0] tom_addr,            // top of memory
  output logic             route_valid,         // decision pulse
  output logic             route_to_dram,       // cycle claimed by DRAM
  output logic             route_to_pci,        // cycle forwarded to PCI
  output region_type       route_region,        // window the cycle hit
  output logic             extended_space_error // sticky error flag
);

  logic       open_q;
  logic       closed_q;
  logic       locked_q;
  logic       global_q;
  logic       error_q;
  logic [7:0] ctrl_word;
  region_type region;
  logic       visible;
  logic       to_dram;
  logic       err_event;
  logic       err_clear;
  logic       ctrl_wr;

  smram_region_match u_match (
    .addr     (host_addr),
    .top_size (top_segment_size),
    .tom_addr (tom_addr),
    .region   (region)
  );

  assign ctrl_wr   = cfg_wr && (cfg_addr == SMM_RAM_CONTROL_OFS);
  assign err_clear = cfg_wr && (cfg_addr == EXT_STATUS_OFS) && cfg_wdata[ERROR_POS]; // R16

  // register image: reserved bit 7 reads zero, base segment hardwired
  assign ctrl_word = {1'b0, open_q, closed_q, locked_q, global_q,
                      COMPAT_BASE_SEGMENT}; // R8

  // global enable and closed bit stay writable always
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      global_q <= SMM_RAM_CONTROL_RST[GLOBAL_POS]; // R20
      closed_q <= SMM_RAM_CONTROL_RST[CLOSED_POS]; // R20
    end else if (ctrl_wr) begin
      global_q <= cfg_wdata[GLOBAL_POS];
      closed_q <= cfg_wdata[CLOSED_POS];
    end
  end

  // lock is set-only; only reset clears it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      locked_q <= SMM_RAM_CONTROL_RST[LOCKED_POS]; // R20
    end else if (ctrl_wr && cfg_wdata[LOCKED_POS]) begin
      locked_q <= 1'b1; // R6
    end
  end

  // open bit: frozen at zero once locked, also cleared by the locking write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      open_q <= SMM_RAM_CONTROL_RST[OPEN_POS]; // R20
    end else if (ctrl_wr && !locked_q) begin
      open_q <= cfg_wdata[OPEN_POS] && !cfg_wdata[LOCKED_POS]; // R6
    end else if (locked_q) begin
      open_q <= 1'b0; // R6
    end
  end

  // space is visible in management mode, or while open and unlocked
  assign visible = !mgmt_mode_active_n || (open_q && !locked_q); // R3 R19

  // steering decision; relies on software keeping open and closed exclusive (R4)
  always_comb begin
    to_dram = 1'b0;
    if (pci_initiator) begin
      to_dram = 1'b0; // R10
    end else if (!global_q) begin
      to_dram = 1'b0; // R1 R18
    end else if (!visible) begin
      to_dram = 1'b0; // R19
    end else if (closed_q && !code_fetch && mgmt_mode_active_n == 1'b0 && !open_q) begin
      to_dram = 1'b0; // R5
    end else begin
      case (region)
        REGION_A:    to_dram = !high_region_enable; // R7 R11 R12 R13 R14
        REGION_HIGH: to_dram = high_region_enable;  // R13 R14 R15
        REGION_TOP:  to_dram = top_segment_enable;  // R12 R14 R17
        default:     to_dram = 1'b0;
      endcase
    end
  end

  // extended window touched from outside management mode with space shut
  assign err_event = !addr_strobe_n && !pci_initiator && global_q
                  && mgmt_mode_active_n && !open_q
                  && ((region == REGION_HIGH && high_region_enable)
                   || (region == REGION_TOP && top_segment_enable)); // R16

  // sticky error, set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      error_q <= 1'b0;
    end else if (err_event) begin
      error_q <= 1'b1; // R16
    end else if (err_clear) begin
      error_q <= 1'b0; // R16
    end
  end

  assign extended_space_error = error_q;

  // routing result registered one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      route_valid   <= 1'b0;
      route_to_dram <= 1'b0;
      route_to_pci  <= 1'b0;
      route_region  <= REGION_NONE;
    end else begin
      route_valid <= !addr_strobe_n;
      if (!addr_strobe_n) begin
        route_to_dram <= to_dram && (region != REGION_NONE); // R9
        route_to_pci  <= !(to_dram && (region != REGION_NONE)); // R9
        route_region  <= region;
      end
    end
  end

  // config read data, zero for unmapped offsets
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      if (cfg_addr == SMM_RAM_CONTROL_OFS) begin
        cfg_rdata <= ctrl_word;
      end else if (cfg_addr == EXT_STATUS_OFS) begin
        cfg_rdata <= {1'b0, error_q, 6'h00};
      end else begin
        cfg_rdata <= 8'h00;
      end
    end
  end

  // checks on the routing and register behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  pci_never_dram_a: assert property ( // R10
    !addr_strobe_n && pci_initiator |=> !route_to_dram && route_to_pci)
    else $error("pci initiator cycle claimed by dram");

  global_off_pci_a: assert property ( // R1
    !addr_strobe_n && !global_q |=> route_to_pci)
    else $error("cycle reached dram with global enable off");

  closed_data_a: assert property ( // R5
    !addr_strobe_n && global_q && closed_q && !open_q && !code_fetch
      |=> !route_to_dram)
    else $error("data reference reached closed space");

  closed_code_a: assert property ( // R5
    !addr_strobe_n && !pci_initiator && global_q && closed_q && !mgmt_mode_active_n
      && code_fetch && region == REGION_A && !high_region_enable |=> route_to_dram)
    else $error("code fetch blocked from closed space");

  open_visible_a: assert property ( // R3
    !addr_strobe_n && !pci_initiator && global_q && open_q && !locked_q
      && !closed_q && region == REGION_A && !high_region_enable |=> route_to_dram)
    else $error("open space not visible");

  shut_pci_a: assert property ( // R19
    !addr_strobe_n && mgmt_mode_active_n && !open_q |=> route_to_pci)
    else $error("space reached while shut");

  lock_sticks_a: assert property ( // R6
    locked_q |=> locked_q && !open_q [*3])
    else $error("lock cleared or open set after lock");

  lock_kills_open_a: assert property ( // R6
    ctrl_wr && cfg_wdata[LOCKED_POS] |=> !open_q && locked_q)
    else $error("locking write left open bit set");

  base_seg_fixed_a: assert property ( // R8
    cfg_rd && cfg_addr == SMM_RAM_CONTROL_OFS |=> cfg_rdata[2:0] == COMPAT_BASE_SEGMENT)
    else $error("base segment not 010");

  err_set_a: assert property ( // R16
    err_event |=> extended_space_error ##1 (extended_space_error || $past(err_clear)))
    else $error("error flag not set on illegal access");

  high_dram_a: assert property ( // R14
    !addr_strobe_n && !pci_initiator && global_q && !closed_q && !mgmt_mode_active_n
      && high_region_enable && top_segment_enable && region == REGION_HIGH
      |=> route_to_dram && route_region == REGION_HIGH)
    else $error("high region not sent to dram");

  exclusive_route_a: assert property ( // R9
    route_valid |-> route_to_dram != route_to_pci)
    else $error("route outputs not exclusive");

  // routing per window and how long the result stands
  a_seg_smm_a: assert property ( // R7 R11
    !addr_strobe_n && !pci_initiator && global_q && !closed_q && !mgmt_mode_active_n
      && region == REGION_A && !high_region_enable
      |=> route_to_dram && route_region == REGION_A)
    else $error("a segment not sent to dram in management mode");

  top_dram_a: assert property ( // R12 R14
    !addr_strobe_n && !pci_initiator && global_q && !closed_q && top_segment_enable
      && (!mgmt_mode_active_n || (open_q && !locked_q)) && region == REGION_TOP
      |=> route_to_dram && route_region == REGION_TOP)
    else $error("top segment not sent to dram");

  high_off_pci_a: assert property ( // R11 R12
    !addr_strobe_n && region == REGION_HIGH && !high_region_enable |=> route_to_pci)
    else $error("disabled high region reached dram");

  a_seg_pci_a: assert property ( // R13 R14
    !addr_strobe_n && region == REGION_A && high_region_enable |=> route_to_pci)
    else $error("a segment reached dram with high region on");

  top_off_pci_a: assert property ( // R11 R13
    !addr_strobe_n && region == REGION_TOP && !top_segment_enable |=> route_to_pci)
    else $error("disabled top segment reached dram");

  outside_pci_a: assert property ( // R9
    !addr_strobe_n && region == REGION_NONE |=> route_to_pci && route_region == REGION_NONE)
    else $error("address outside all windows reached dram");

  route_pulse_a: assert property ( // R9
    route_valid |-> !$past(addr_strobe_n))
    else $error("route valid without a strobe");

  route_hold_a: assert property ( // R9
    addr_strobe_n |=> !route_valid && $stable(route_to_dram) && $stable(route_to_pci)
      && $stable(route_region))
    else $error("route result changed without a strobe");

  // error flag and register image
  err_clear_a: assert property ( // R16
    err_clear && !err_event |=> !extended_space_error)
    else $error("error flag not cleared by write of one");

  set_wins_a: assert property ( // R16
    err_event && err_clear |=> extended_space_error)
    else $error("clear beat a new error in the same cycle");

  err_hold_a: assert property ( // R16
    !err_event && !err_clear |=> $stable(extended_space_error))
    else $error("error flag changed with no event or clear");

  ctrl_reset_a: assert property ( // R20
    $fell(rst) |-> ctrl_word == SMM_RAM_CONTROL_RST && !error_q)
    else $error("control register not at reset value");

  ctrl_writable_a: assert property ( // R6
    ctrl_wr |=> closed_q == $past(cfg_wdata[CLOSED_POS])
      && global_q == $past(cfg_wdata[GLOBAL_POS]))
    else $error("closed or global bit ignored a write");

  a_seg_dram_c: cover property (route_valid && route_to_dram && route_region == REGION_A);
  top_dram_c:   cover property (route_valid && route_to_dram && route_region == REGION_TOP);
  lock_set_c:   cover property (ctrl_wr && cfg_wdata[LOCKED_POS] && !locked_q);
  err_flag_c:   cover property (err_event ##[1:20] err_clear);
  set_wins_c:   cover property (err_event && err_clear);

endmodule

/* tb/host_bus_model.sv */
`timescale 1ns/1ps
// host side: issues memory cycles, scrambles its lines once released
module host_bus_model (
  output logic        addr_strobe_n, // cycle start, active low
  output logic [31:0] host_addr,     // cycle address
  output logic        code_fetch,    // code fetch or data
  output logic        pci_initiator  // cycle from a pci master
);
  // idle bus at time zero
  initial begin
    addr_strobe_n = 1'b1;
    host_addr     = 32'h0000_0000;
    code_fetch    = 1'b0;
    pci_initiator = 1'b0;
  end
  // start one cycle, called just after a falling edge
  task automatic drive(input logic [31:0] a, input logic cf, input logic pi);
    addr_strobe_n = 1'b0;
    host_addr     = a;
    code_fetch    = cf;
    pci_initiator = pi;
  endtask
  // released lines show the inverse of their last value
  task automatic release_bus();
    addr_strobe_n = 1'b1;
    host_addr     = ~host_addr;
    code_fetch    = ~code_fetch;
    pci_initiator = ~pci_initiator;
  endtask
endmodule

/* tb/tb_smram_access_decoder.sv */
`timescale 1ns/1ps
// self-checking bench for the management memory steering block
module tb_smram_access_decoder import smram_pkg::*; ();
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_wr = 1'b0;
  logic        cfg_rd = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [7:0]  cfg_wdata = 8'h00;
  logic [7:0]  cfg_rdata;
  logic        addr_strobe_n;
  logic [31:0] host_addr;
  logic        code_fetch;
  logic        pci_initiator;
  logic        mgmt_mode_active_n = 1'b1;
  logic        high_region_enable = 1'b0;
  logic        top_segment_enable = 1'b0;
  logic [1:0]  top_segment_size = 2'b00;
  logic [31:0] tom_addr = 32'h0400_0000;
  logic        route_valid;
  logic        route_to_dram;
  logic        route_to_pci;
  region_type  route_region;
  logic        extended_space_error;
  logic        g, lk, cl, op, err; // bench copy of control state
  int          error_cnt = 0;
  int          num_checks = 0;

  // clock and hang guard
  always #5 sys_clk = ~sys_clk;
  initial begin
    #900_000;
    error_cnt++;
    end_sim();
  end

  host_bus_model i_host_bus_model (.addr_strobe_n(addr_strobe_n), .host_addr(host_addr),
    .code_fetch(code_fetch), .pci_initiator(pci_initiator));
  smram_access_decoder i_smram_access_decoder (.sys_clk(sys_clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .addr_strobe_n(addr_strobe_n), .host_addr(host_addr), .code_fetch(code_fetch),
    .pci_initiator(pci_initiator), .mgmt_mode_active_n(mgmt_mode_active_n),
    .high_region_enable(high_region_enable), .top_segment_enable(top_segment_enable),
    .top_segment_size(top_segment_size), .tom_addr(tom_addr), .route_valid(route_valid),
    .route_to_dram(route_to_dram), .route_to_pci(route_to_pci), .route_region(route_region),
    .extended_space_error(extended_space_error));

  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // expected window of an address
  function automatic region_type exp_region(input logic [31:0] a);
    logic [31:0] sz;
    sz = 32'h0002_0000 << top_segment_size;
    if (a >= 32'h000A_0000 && a <= 32'h000B_FFFF) return REGION_A;
    if (a >= 32'h100A_0000 && a <= 32'h100F_FFFF) return REGION_HIGH;
    if (a >= tom_addr - sz && a < tom_addr) return REGION_TOP;
    return REGION_NONE;
  endfunction

  // expected steering decision
  function automatic logic exp_dram(input region_type r, input logic cf, input logic pi);
    if (!g || pi || !(!mgmt_mode_active_n || (op && !lk)) || (cl && !cf)) return 1'b0;
    case (r)
      REGION_A: return !high_region_enable;
      REGION_HIGH: return high_region_enable;
      REGION_TOP: return top_segment_enable;
      default: return 1'b0;
    endcase
  endfunction

  // config write, bench state follows
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
    if (a == 8'h72) begin
      {g, cl} = {d[3], d[5]};
      if (!lk) {lk, op} = {d[4], d[6] & ~d[4]};
    end
    if (a == 8'h71 && d[6]) err = 1'b0;
  endtask

  // config read against expected byte
  task automatic cfg_read(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    check("cfg_rdata", cfg_rdata, e);
  endtask

  // one host cycle and its decision
  task automatic host_op(input logic [31:0] a, input logic cf, input logic pi);
    region_type r;
    logic       d;
    @(negedge sys_clk);
    r = exp_region(a);
    d = exp_dram(r, cf, pi);
    if (g && !pi && mgmt_mode_active_n && !op && ((r == REGION_HIGH && high_region_enable)
        || (r == REGION_TOP && top_segment_enable))) err = 1'b1;
    i_host_bus_model.drive(a, cf, pi);
    @(negedge sys_clk);
    i_host_bus_model.release_bus();
    check("route_valid", route_valid, 1);
    check("route_to_dram", route_to_dram, d);
    check("route_to_pci", route_to_pci, !d);
    check("route_region", route_region, r);
    check("error_flag", extended_space_error, err);
  endtask

  // random settings and cycles in all windows
  task automatic rand_phase(input int n);
    logic [7:0]  d;
    logic [31:0] sz;
    for (int i = 0; i < n; i++) begin
      {mgmt_mode_active_n, high_region_enable, top_segment_enable} = 3'($urandom);
      top_segment_size = 2'($urandom);
      sz = 32'h0002_0000 << top_segment_size;
      d = 8'($urandom);
      if (d[6]) d[5] = 1'b0;
      if (!lk) d[4] = 1'b0;
      if (i % 4 == 0) cfg_write(8'h72, d);
      case ($urandom % 4)
        0: host_op(32'h000A_0000 + $urandom % 32'h0002_0000, 1'($urandom), $urandom % 8 == 0);
        1: host_op(32'h100A_0000 + $urandom % 32'h0006_0000, 1'($urandom), $urandom % 8 == 0);
        2: host_op(tom_addr - sz + $urandom % sz, 1'($urandom), $urandom % 8 == 0);
        default: host_op($urandom, 1'($urandom), 1'b0);
      endcase
      if (i % 8 == 1) cfg_read(8'h72, {1'b0, op, cl, lk, g, 3'b010});
      if (i % 8 == 3) cfg_read(8'h71, {1'b0, err, 6'h00});
      if (i % 8 == 5) cfg_write(8'h71, 8'h40);
    end
  endtask

  // reset held two cycles, then defaults
  task automatic reset_dut();
    rst = 1'b1;
    {g, lk, cl, op, err} = 5'h00;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    check("route_valid", route_valid, 0);
    cfg_read(8'h72, 8'h02);
    cfg_read(8'h71, 8'h00);
    cfg_write(8'h73, 8'hFF);
    cfg_read(8'h73, 8'h00);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    logic [31:0] edges [6];
    void'($urandom(32'he1dd));
    reset_dut();
    $display("test reset_values done");
    rand_phase(300);
    $display("test random_unlocked done");
    cfg_write(8'h72, 8'h48);
    {mgmt_mode_active_n, high_region_enable, top_segment_enable} = 3'b101;
    edges = '{32'h000B_FFFF, 32'h000C_0000, 32'h100F_FFFF, 32'h1010_0000, tom_addr - 1, tom_addr};
    foreach (edges[k]) host_op(edges[k], 1'b0, 1'b0);
    $display("test window_edges done");
    cfg_write(8'h72, 8'h08);
    cfg_write(8'h72, 8'h18);
    cfg_write(8'h72, 8'h48);
    cfg_read(8'h72, 8'h1A);
    cfg_write(8'h72, 8'h00);
    cfg_read(8'h72, 8'h12);
    rand_phase(200);
    $display("test random_locked done");
    reset_dut();
    $display("test second_reset done");
    // offending access and clear in one cycle: the set must win
    cfg_write(8'h72, 8'h08);
    {mgmt_mode_active_n, high_region_enable, top_segment_enable} = 3'b101;
    @(negedge sys_clk);
    cfg_addr = 8'h71;
    cfg_wdata = 8'h40;
    cfg_wr = 1'b1;
    i_host_bus_model.drive(tom_addr - 1, 1'b0, 1'b0);
    @(negedge sys_clk);
    cfg_wr = 1'b0;
    i_host_bus_model.release_bus();
    check("error_flag", extended_space_error, 1);
    check("route_to_pci", route_to_pci, 1);
    err = 1'b1;
    cfg_read(8'h71, 8'h40);
    cfg_write(8'h71, 8'h40);
    cfg_read(8'h71, 8'h00);
    $display("test error_set_wins done");
    end_sim();
  end
endmodule
